// file: src/vfrc_pkg.sv
// Constants and types shared by the output-voltage fault-response block.
// Assumes a 50 MHz system clock and a byte-wide command set on the SMBus link.
package vfrc_pkg;
  // ****************************************************************
  // Command codes
  // ****************************************************************
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_STORE_ALL = 8'h11;
  localparam logic [7:0] CMD_RESTORE_ALL = 8'h12;
  localparam logic [7:0] CMD_OV_RESP = 8'h41;
  localparam logic [7:0] CMD_UV_RESP = 8'h45;
  localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] CMD_STATUS_VOUT = 8'h7A;
  localparam logic [7:0] CMD_STATUS_CML = 8'h7E;
  // ****************************************************************
  // Fields, reset values and status bit positions
  // ****************************************************************
  localparam int IGN_BIT = 7;
  localparam int RETRY_BIT = 5;
  localparam int RETRY_LO = 3;
  localparam logic [2:0] RETRY_ALL_OFF = 3'h0;
  localparam logic [2:0] RETRY_ALL_ON = 3'h7;
  localparam logic [7:0] RESP_RESET = 8'hBF;
  localparam logic [7:0] READ_FILL = 8'hFF;
  localparam int SB_OVF_BIT = 5;
  localparam int SB_CML_BIT = 1;
  localparam int SB_OTH_BIT = 0;
  localparam int SW_VOUT_BIT = 7;
  localparam int SV_OVF_BIT = 7;
  localparam int SV_UVF_BIT = 4;
  localparam int CML_IVC_BIT = 7;
  localparam int CML_IVD_BIT = 6;
  // Arbitrary neutral value; the DEV_ADDR parameter sets the real address.
  localparam logic [6:0] DEV_ADDR_DEF = 7'h10;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned TON_RISE_US = 3000;
  localparam int unsigned TON_RISE_CYCLES_DEF = TON_RISE_US * CLK_MHZ;
  localparam logic [2:0] DELAY_PERIODS = 3'h7;
  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    PWR_RUN = 2'b00,
    PWR_WAIT = 2'b01,
    PWR_START = 2'b11,
    PWR_OFF = 2'b10
  } vfrc_pwr_t;
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b000,
    BUS_ADDR = 3'b001,
    BUS_AACK = 3'b011,
    BUS_WDATA = 3'b010,
    BUS_RDATA = 3'b110,
    BUS_RACK = 3'b111,
    BUS_SKIP = 3'b100
  } vfrc_bus_t;
endpackage : vfrc_pkg

// file: src/vfrc_top.sv
// Output-voltage fault-response registers, SMBus byte slave and retry sequencer.
// Assumes fault detector levels on sys_clk and SMBus pins from outside the clock domain.
//
// Summary of operation
// R01 - Retry field 000: no restart, output stays off until faults are cleared.
// R02 - Retry field 111: soft-start repeats endlessly until run_cmd drops or a fault with retry field 000 latches off.
// R03 - Retry writes other than 000/111 are rejected, setting cml, invalid data and alert.
// R04 - Only retry bit 5 is kept in storage; the other two follow it.
// R05 - Delay 000 means no restart delay, only with retry off; output stays off.
// R06 - Delay 111 waits seven rise periods before soft-start, only with retry on.
// R07 - Delay bits read as copies of retry bit 5.
// R08 - Retry and delay fields reset to all ones.
// R09 - Undervoltage sets oth, vout word bit, undervoltage bit and raises alert.
// R10 - Undervoltage is judged by the detector against the percent threshold limits.
// R11 - Follower strap makes the response commands NACK, flag invalid command, alert.
// R12 - Store-all command saves the response registers to nonvolatile copy.
// R13 - Default undervoltage response is shutdown then restart after seven rise periods.
// R14 - Undervoltage ignore-select chooses ignore or shutdown-retry, default 1.
// R15 - Ignore-select 0 keeps running while status bits and alert are still set.
// R16 - Ignore-select 1 shuts output down and restarts per retry field.
// R17 - Layout: bit 7 ignore, bit 6 zero, bits 5-3 retry, bits 2-0 delay.
// R18 - Overvoltage sets its status-byte bit, vout word bit, vout bit and alert.
// R19 - Overvoltage ignore-select defaults 1; 0 ignores, 1 shuts down and retries.
`timescale 1ns/1ps
module vfrc_top #(
  parameter int unsigned TON_RISE_CYCLES = vfrc_pkg::TON_RISE_CYCLES_DEF,
  parameter logic [6:0] DEV_ADDR = vfrc_pkg::DEV_ADDR_DEF
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic smbalert_out,
  output logic smbalert_oe,
  input wire logic follower_strap,
  input wire logic run_cmd,
  input wire logic uv_detect,
  input wire logic ov_detect,
  output logic power_en,
  output logic soft_start
);
  import vfrc_pkg::*;

  function automatic logic [7:0] resp_image(input logic ign, input logic retry);
    resp_image = {ign, 1'b0, {3{retry}}, {3{retry}}};
  endfunction : resp_image

  function automatic logic [7:0] bit_at(input logic v, input int pos);
    bit_at = 8'(v) << pos;
  endfunction : bit_at

  // ****************************************************************
  // Pin synchronisers and strap capture
  // ****************************************************************
  logic [2:0] scl_sy;
  logic [2:0] sda_sy;
  logic [1:0] strap_sy;
  logic follower;
  logic [1:0] strap_wait;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scl_sy <= 3'h7;
      sda_sy <= 3'h7;
      strap_sy <= 2'h0;
    end else begin
      scl_sy <= {scl_sy[1:0], scl};
      sda_sy <= {sda_sy[1:0], sda_in};
      strap_sy <= {strap_sy[0], follower_strap};
    end
  end

  // The strap is caught once after reset so a glitch later cannot unlock commands.
  // Capture waits for the third edge, when the synchroniser holds a real pin sample.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      follower <= 1'b0;
      strap_wait <= 2'h0;
    end else if (strap_wait != 2'h3) begin
      strap_wait <= strap_wait + 2'h1;
      if (strap_wait == 2'h2) begin
        follower <= strap_sy[1];
      end
    end
  end

  wire scl_rise = scl_sy[1] & ~scl_sy[2];
  wire scl_fall = ~scl_sy[1] & scl_sy[2];
  wire start_cond = scl_sy[1] & scl_sy[2] & sda_sy[2] & ~sda_sy[1];
  wire stop_cond = scl_sy[1] & scl_sy[2] & ~sda_sy[2] & sda_sy[1];

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  vfrc_bus_t bus_st;
  logic [2:0] bit_cnt;
  logic [7:0] shreg;
  logic byte_done;
  logic rd_mode;
  logic byte_idx;
  logic second;
  logic [7:0] cmd;
  logic uv_ign;
  logic uv_retry;
  logic ov_ign;
  logic ov_retry;
  logic nv_uv_ign;
  logic nv_uv_retry;
  logic nv_ov_ign;
  logic nv_ov_retry;
  logic sb_ovf;
  logic sb_oth;
  logic sb_cml;
  logic sw_vfw;
  logic sv_ovf;
  logic sv_uvf;
  logic cml_ivc;
  logic cml_ivd;

  wire byte_end = scl_fall & byte_done;
  wire in_cmd = byte_end && (bus_st == BUS_WDATA) && !byte_idx;
  wire in_data = byte_end && (bus_st == BUS_WDATA) && byte_idx;
  wire resp_code = (shreg == CMD_UV_RESP) || (shreg == CMD_OV_RESP);
  wire send_code = (shreg == CMD_CLEAR_FAULTS) || (shreg == CMD_STORE_ALL) || (shreg == CMD_RESTORE_ALL);
  wire stat_code = (shreg == CMD_STATUS_BYTE) || (shreg == CMD_STATUS_WORD) || (shreg == CMD_STATUS_VOUT)
                   || (shreg == CMD_STATUS_CML);
  wire locked = follower & resp_code; // [R11]
  wire cmd_ack = (resp_code | send_code | stat_code) & ~locked;
  wire ivc_evt = in_cmd & ~cmd_ack; // [R11]
  wire cmd_is_resp = (cmd == CMD_UV_RESP) || (cmd == CMD_OV_RESP);
  wire retry_ok = (shreg[RETRY_BIT:RETRY_LO] == RETRY_ALL_OFF) || (shreg[RETRY_BIT:RETRY_LO] == RETRY_ALL_ON);
  wire resp_wr = in_data & cmd_is_resp & ~rd_mode;
  wire wr_bad = resp_wr & ~retry_ok; // [R03]
  wire uv_wr = resp_wr & retry_ok & (cmd == CMD_UV_RESP);
  wire ov_wr = resp_wr & retry_ok & (cmd == CMD_OV_RESP);
  wire clr_evt = in_cmd & (shreg == CMD_CLEAR_FAULTS);
  wire store_evt = in_cmd & (shreg == CMD_STORE_ALL);
  wire restore_evt = in_cmd & (shreg == CMD_RESTORE_ALL);
  wire [7:0] uv_image = resp_image(uv_ign, uv_retry); // [R07] [R17]
  wire [7:0] ov_image = resp_image(ov_ign, ov_retry); // [R07] [R17]
  wire [7:0] status_byte = bit_at(sb_ovf, SB_OVF_BIT) | bit_at(sb_cml, SB_CML_BIT) | bit_at(sb_oth, SB_OTH_BIT);
  wire [7:0] status_hi = bit_at(sw_vfw, SW_VOUT_BIT);
  wire [7:0] status_vout = bit_at(sv_ovf, SV_OVF_BIT) | bit_at(sv_uvf, SV_UVF_BIT);
  wire [7:0] status_cml = bit_at(cml_ivc, CML_IVC_BIT) | bit_at(cml_ivd, CML_IVD_BIT);
  wire [7:0] rd_first = (cmd == CMD_UV_RESP) ? uv_image :
                        (cmd == CMD_OV_RESP) ? ov_image :
                        (cmd == CMD_STATUS_BYTE || cmd == CMD_STATUS_WORD) ? status_byte :
                        (cmd == CMD_STATUS_VOUT) ? status_vout :
                        (cmd == CMD_STATUS_CML) ? status_cml : READ_FILL;
  wire [7:0] tx_byte = !second ? rd_first : (cmd == CMD_STATUS_WORD) ? status_hi : READ_FILL;
  wire load_tx = (bus_st == BUS_RACK) || ((bus_st == BUS_AACK) && rd_mode && sda_oe);

  // ****************************************************************
  // SMBus byte slave
  // ****************************************************************
  // No clock stretching: the host must allow each byte to be decoded within one sys_clk.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_st <= BUS_IDLE;
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
      byte_done <= 1'b0;
      rd_mode <= 1'b0;
      byte_idx <= 1'b0;
      second <= 1'b0;
      cmd <= 8'h00;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end else if (start_cond) begin
      bus_st <= BUS_ADDR;
      bit_cnt <= 3'h0;
      byte_done <= 1'b0;
      byte_idx <= 1'b0;
      second <= 1'b0;
      sda_oe <= 1'b0;
    end else if (stop_cond) begin
      bus_st <= BUS_IDLE;
      sda_oe <= 1'b0;
    end else if (scl_rise) begin
      case (bus_st)
        BUS_ADDR, BUS_WDATA: begin
          shreg <= {shreg[6:0], sda_sy[1]};
          bit_cnt <= bit_cnt + 3'h1;
          byte_done <= (bit_cnt == 3'h7);
        end
        BUS_RACK: begin
          if (sda_sy[1]) begin
            bus_st <= BUS_SKIP;
          end else begin
            second <= 1'b1;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      if (load_tx) begin
        bus_st <= BUS_RDATA;
        shreg <= {tx_byte[6:0], 1'b0};
        sda_oe <= ~tx_byte[7];
        bit_cnt <= 3'h1;
      end else begin
        case (bus_st)
          BUS_ADDR: begin
            if (byte_done) begin
              byte_done <= 1'b0;
              rd_mode <= shreg[0];
              bus_st <= (shreg[7:1] == DEV_ADDR) ? BUS_AACK : BUS_SKIP;
              sda_oe <= (shreg[7:1] == DEV_ADDR);
            end
          end
          BUS_WDATA: begin
            if (byte_done) begin
              byte_done <= 1'b0;
              bus_st <= BUS_AACK;
              sda_oe <= byte_idx ? cmd_is_resp : cmd_ack; // [R11]
              byte_idx <= 1'b1;
              if (!byte_idx) begin
                cmd <= shreg;
              end
            end
          end
          BUS_AACK: begin
            bus_st <= sda_oe ? BUS_WDATA : BUS_SKIP;
            bit_cnt <= 3'h0;
            sda_oe <= 1'b0;
          end
          BUS_RDATA: begin
            if (bit_cnt == 3'h0) begin
              bus_st <= BUS_RACK;
              sda_oe <= 1'b0;
            end else begin
              sda_oe <= ~shreg[7];
              shreg <= {shreg[6:0], 1'b0};
              bit_cnt <= bit_cnt + 3'h1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Response registers and nonvolatile copy
  // ****************************************************************
  // One retry bit is held; the three field bits and the delay bits are rebuilt from it.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      uv_ign <= RESP_RESET[IGN_BIT]; // [R08] [R13] [R14]
      uv_retry <= RESP_RESET[RETRY_BIT]; // [R08] [R13]
      ov_ign <= RESP_RESET[IGN_BIT]; // [R19]
      ov_retry <= RESP_RESET[RETRY_BIT]; // [R08]
      nv_uv_ign <= RESP_RESET[IGN_BIT];
      nv_uv_retry <= RESP_RESET[RETRY_BIT];
      nv_ov_ign <= RESP_RESET[IGN_BIT];
      nv_ov_retry <= RESP_RESET[RETRY_BIT];
    end else begin
      if (uv_wr) begin
        uv_ign <= shreg[IGN_BIT];
        uv_retry <= shreg[RETRY_BIT]; // [R04]
      end else if (restore_evt) begin
        uv_ign <= nv_uv_ign;
        uv_retry <= nv_uv_retry; // [R04]
      end
      if (ov_wr) begin
        ov_ign <= shreg[IGN_BIT];
        ov_retry <= shreg[RETRY_BIT];
      end else if (restore_evt) begin
        ov_ign <= nv_ov_ign;
        ov_retry <= nv_ov_retry;
      end
      if (store_evt) begin
        nv_uv_ign <= uv_ign; // [R12]
        nv_uv_retry <= uv_retry; // [R04] [R12]
        nv_ov_ign <= ov_ign;
        nv_ov_retry <= ov_retry;
      end
    end
  end

  // ****************************************************************
  // Status bits and alert
  // ****************************************************************
  // The detector levels already carry the percent-limit comparison. [R10]
  // A set arriving with a clear wins, so no fault is lost.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sb_ovf <= 1'b0;
      sb_oth <= 1'b0;
      sb_cml <= 1'b0;
      sw_vfw <= 1'b0;
      sv_ovf <= 1'b0;
      sv_uvf <= 1'b0;
      cml_ivc <= 1'b0;
      cml_ivd <= 1'b0;
      smbalert_oe <= 1'b0;
      smbalert_out <= 1'b0;
    end else begin
      sb_oth <= uv_detect | (sb_oth & ~clr_evt); // [R09] [R15]
      sv_uvf <= uv_detect | (sv_uvf & ~clr_evt); // [R09]
      sb_ovf <= ov_detect | (sb_ovf & ~clr_evt); // [R18]
      sv_ovf <= ov_detect | (sv_ovf & ~clr_evt); // [R18]
      sw_vfw <= uv_detect | ov_detect | (sw_vfw & ~clr_evt); // [R09] [R18]
      sb_cml <= wr_bad | ivc_evt | (sb_cml & ~clr_evt); // [R03] [R11]
      cml_ivd <= wr_bad | (cml_ivd & ~clr_evt); // [R03]
      cml_ivc <= ivc_evt | (cml_ivc & ~clr_evt); // [R11]
      smbalert_oe <= |{sb_ovf, sb_oth, sb_cml, sw_vfw}; // [R03] [R09] [R15]
    end
  end

  // ****************************************************************
  // Shutdown and retry sequencer
  // ****************************************************************
  vfrc_pwr_t pwr_st;
  logic uv_prev;
  logic ov_prev;
  logic latched;
  logic [2:0] period_cnt;
  logic [31:0] div_cnt;

  wire uv_rise = uv_detect & ~uv_prev;
  wire ov_rise = ov_detect & ~ov_prev;
  wire uv_shut = uv_rise & uv_ign; // [R14] [R16]
  wire ov_shut = ov_rise & ov_ign; // [R19]
  wire shut_evt = (uv_shut | ov_shut) & run_cmd & (pwr_st != PWR_OFF);
  wire no_retry = (uv_shut & ~uv_retry) | (ov_shut & ~ov_retry); // [R01] [R05]
  wire rise_tick = (div_cnt == TON_RISE_CYCLES - 1);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      uv_prev <= 1'b0;
      ov_prev <= 1'b0;
      latched <= 1'b0;
    end else begin
      uv_prev <= uv_detect;
      ov_prev <= ov_detect;
      latched <= (shut_evt & no_retry) | (latched & ~clr_evt); // [R01]
    end
  end

  // The divider makes the one-cycle rise-period enable and restarts on each transition.
  always_ff @(posedge sys_clk) begin
    if (rst || shut_evt || rise_tick || pwr_st == PWR_RUN || pwr_st == PWR_OFF) begin
      div_cnt <= 32'h0;
    end else begin
      div_cnt <= div_cnt + 32'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pwr_st <= PWR_OFF;
      period_cnt <= 3'h0;
    end else if (!run_cmd) begin
      pwr_st <= PWR_OFF; // [R02]
    end else if (shut_evt) begin
      pwr_st <= no_retry ? PWR_OFF : PWR_WAIT; // [R01] [R02] [R05] [R16]
      period_cnt <= 3'h0;
    end else begin
      case (pwr_st)
        PWR_WAIT: begin
          if (rise_tick) begin
            period_cnt <= period_cnt + 3'h1;
            if (period_cnt == DELAY_PERIODS - 3'h1) begin
              pwr_st <= PWR_START; // [R06] [R13]
            end
          end
        end
        PWR_START: begin
          if (rise_tick) begin
            pwr_st <= PWR_RUN;
          end
        end
        PWR_OFF: begin
          if (!latched) begin
            pwr_st <= PWR_START;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      power_en <= 1'b0;
      soft_start <= 1'b0;
    end else begin
      power_en <= (pwr_st == PWR_RUN) || (pwr_st == PWR_START);
      soft_start <= (pwr_st == PWR_START);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [31:0] wait_len;
  always_ff @(posedge sys_clk) begin
    if (rst || shut_evt || pwr_st != PWR_WAIT) begin
      wait_len <= 32'h0;
    end else begin
      wait_len <= wait_len + 32'h1;
    end
  end

  property p_no_retry;
    shut_evt && no_retry |=> pwr_st == PWR_OFF && latched ##1 !power_en;
  endproperty
  a_no_retry: assert property (p_no_retry) else $error("no-retry fault did not latch off"); // [R01]
  property p_retry_on;
    shut_evt && !no_retry |=> pwr_st == PWR_WAIT ##1 !power_en;
  endproperty
  a_retry_on: assert property (p_retry_on) else $error("retry fault did not enter delay"); // [R02]
  property p_reject;
    wr_bad |=> sb_cml && cml_ivd && uv_retry == $past(uv_retry) && ov_retry == $past(ov_retry) ##1 smbalert_oe;
  endproperty
  a_reject: assert property (p_reject) else $error("bad retry write not rejected"); // [R03]
  property p_store;
    store_evt |=> nv_uv_retry == $past(uv_retry) && nv_uv_ign == $past(uv_ign);
  endproperty
  a_store: assert property (p_store) else $error("store did not copy response"); // [R04]
  property p_delay;
    $past(pwr_st) == PWR_WAIT && pwr_st == PWR_START |-> wait_len == 32'(DELAY_PERIODS) * TON_RISE_CYCLES;
  endproperty
  a_delay: assert property (p_delay) else $error("restart delay length wrong"); // [R06]
  property p_image;
    uv_wr |=> uv_image == {$past(shreg[IGN_BIT]), 1'b0, {6{$past(shreg[RETRY_BIT])}}};
  endproperty
  a_image: assert property (p_image) else $error("response readback wrong"); // [R07]
  property p_reset;
    $fell(rst) |-> uv_image == RESP_RESET && ov_image == RESP_RESET;
  endproperty
  a_reset: assert property (p_reset) else $error("response reset value wrong"); // [R08]
  property p_uv_status;
    uv_detect |=> sb_oth && sw_vfw && sv_uvf ##1 smbalert_oe;
  endproperty
  a_uv_status: assert property (p_uv_status) else $error("undervoltage status missing"); // [R09]
  property p_follower;
    in_cmd && follower && shreg == CMD_UV_RESP |=> !sda_oe && cml_ivc && sb_cml;
  endproperty
  a_follower: assert property (p_follower) else $error("follower access not refused"); // [R11]
  property p_ignore;
    uv_rise && !uv_ign && !ov_shut && run_cmd && pwr_st == PWR_RUN |=> pwr_st == PWR_RUN;
  endproperty
  a_ignore: assert property (p_ignore) else $error("ignored fault stopped output"); // [R15]
endmodule : vfrc_top

// file: testbench/vfrc_host.sv
// SMBus host model that drives the response block's link from the far side.
// Assumes SDA is a pulled-up wire resolved by the bench from both parties' pulls.
`timescale 1ns/1ps
module vfrc_host (
  input wire logic sys_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull,
  output logic [15:0] rd_data,
  output logic cmd_ack
);
  import vfrc_pkg::*;
  // ****************************************************************
  // Bit and frame timing
  // ****************************************************************
  // The clock idles high between frames; each phase lasts four system clocks.
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    rd_data = 16'h0000;
    cmd_ack = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick
  task automatic bit_io(input logic b, output logic s);
    tick(1);
    sda_pull = ~b;
    tick(3);
    scl = 1'b1;
    tick(4);
    s = sda_line;
    scl = 1'b0;
  endtask : bit_io
  task automatic start();
    tick(1);
    sda_pull = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(4);
    sda_pull = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask : start
  task automatic xbyte(input logic [7:0] w, input logic last, output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(w[i], r[i]);
    end
    bit_io(last, a);
    ack = ~a;
  endtask : xbyte
  // ****************************************************************
  // Whole transactions
  // ****************************************************************
  task automatic xfer(input logic [7:0] c, input logic [7:0] d, input int nw, input int nr);
    logic [7:0] r;
    logic a;
    start();
    xbyte({DEV_ADDR_DEF, 1'b0}, 1'b1, r, a);
    xbyte(c, 1'b1, r, cmd_ack);
    if (nw > 0) begin
      xbyte(d, 1'b1, r, a);
    end
    if (nr > 0) begin
      start();
      xbyte({DEV_ADDR_DEF, 1'b1}, 1'b1, r, a);
      for (int k = 0; k < nr; k++) begin
        xbyte(8'hFF, k == nr - 1, r, a);
        rd_data = {rd_data[7:0], r};
      end
    end
    tick(1);
    sda_pull = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(4);
    sda_pull = 1'b0;
    tick(4);
  endtask : xfer
endmodule : vfrc_host

// file: testbench/vout_fault_response_ctrl_bench.sv
// Self-checking bench for the fault-response block and its SMBus registers.
// Assumes the host model in vfrc_host and a shortened soft-start period of 8 cycles.
`timescale 1ns/1ps
module vout_fault_response_ctrl_bench;
  import vfrc_pkg::*;
  logic sys_clk, rst, follower_strap, run_cmd, uv_detect, ov_detect, scl, sda_pull;
  logic sda_out, sda_oe, smbalert_out, smbalert_oe, power_en, soft_start, pe, a;
  logic [15:0] rd_data, obs;
  logic [15:0] q[$];
  logic [7:0] cur, d;
  logic cmd_ack;
  int miscompares, cmp_count, seed, n;
  event ev;
  wire logic sda_line = ~((sda_oe & ~sda_out) | sda_pull);
  vfrc_top #(.TON_RISE_CYCLES(8)) DUT (.sys_clk(sys_clk), .rst(rst), .scl(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .smbalert_out(smbalert_out), .smbalert_oe(smbalert_oe),
    .follower_strap(follower_strap), .run_cmd(run_cmd), .uv_detect(uv_detect), .ov_detect(ov_detect),
    .power_en(power_en), .soft_start(soft_start));
  vfrc_host host (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull),
    .rd_data(rd_data), .cmd_ack(cmd_ack));
  // ****************************************************************
  // Clock, checking and closing
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask : check
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  // Each note waits one clock so the watcher is armed again before the next one.
  task automatic see(input logic [15:0] v, input logic [15:0] e);
    q.push_back(e);
    obs = v;
    ->ev;
    @(negedge sys_clk);
  endtask : see
  initial begin
    forever begin
      @(ev);
      check(obs, q.pop_front());
    end
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    miscompares++;
    close_out();
  end
  // ****************************************************************
  // Stimulus helpers
  // ****************************************************************
  task automatic tick(input int k);
    repeat (k) @(negedge sys_clk);
  endtask : tick
  task automatic rd(input logic [7:0] c, input logic [7:0] e);
    host.xfer(c, 8'h00, 0, 1);
    see({8'h00, rd_data[7:0]}, {8'h00, e});
  endtask : rd
  task automatic do_reset(input logic strap);
    rst = 1'b1;
    follower_strap = strap;
    tick(16);
    rst = 1'b0;
    tick(6);
  endtask : do_reset
  task automatic fault(input logic ov);
    ov_detect = ov;
    uv_detect = ~ov;
    tick(2);
    ov_detect = 1'b0;
    uv_detect = 1'b0;
  endtask : fault
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    seed = 32'hB6CA;
    rst = 1'b1;
    follower_strap = 1'b0;
    run_cmd = 1'b1;
    uv_detect = 1'b0;
    ov_detect = 1'b0;
    do_reset(1'b0);
    rd(CMD_UV_RESP, RESP_RESET);
    rd(CMD_OV_RESP, RESP_RESET);
    uv_detect = 1'b1;
    pe = 1'b1;
    for (n = 0; n < 300 && soft_start !== 1'b1; n++) begin
      @(negedge sys_clk);
      if (n == 2) uv_detect = 1'b0;
      if (n == 50) pe = power_en;
    end
    see(16'(pe), 16'h0000);
    see(16'(n >= 56 && n <= 62), 16'h0001);
    tick(12);
    see(16'({soft_start, power_en}), 16'h0001);
    see(16'(smbalert_oe), 16'h0001);
    rd(CMD_STATUS_BYTE, 8'h01);
    rd(CMD_STATUS_VOUT, 8'h10);
    host.xfer(CMD_STATUS_WORD, 8'h00, 0, 2);
    see(rd_data, 16'h0180);
    host.xfer(CMD_CLEAR_FAULTS, 8'h00, 0, 0);
    tick(4);
    see(16'(smbalert_oe), 16'h0000);
    host.xfer(CMD_OV_RESP, 8'h00, 1, 0);
    fault(1'b1);
    tick(10);
    see(16'(power_en), 16'h0001);
    rd(CMD_STATUS_BYTE, 8'h20);
    rd(CMD_STATUS_VOUT, 8'h80);
    host.xfer(CMD_CLEAR_FAULTS, 8'h00, 0, 0);
    host.xfer(CMD_UV_RESP, 8'h80, 1, 0);
    rd(CMD_UV_RESP, 8'h80);
    fault(1'b0);
    tick(100);
    see(16'(power_en), 16'h0000);
    host.xfer(CMD_CLEAR_FAULTS, 8'h00, 0, 0);
    tick(20);
    see(16'(power_en), 16'h0001);
    host.xfer(CMD_UV_RESP, 8'h00, 1, 0);
    fault(1'b0);
    tick(10);
    see(16'({power_en, smbalert_oe}), 16'h0003);
    run_cmd = 1'b0;
    tick(4);
    see(16'(power_en), 16'h0000);
    run_cmd = 1'b1;
    tick(20);
    see(16'(power_en), 16'h0001);
    host.xfer(CMD_CLEAR_FAULTS, 8'h00, 0, 0);
    host.xfer(CMD_STORE_ALL, 8'h00, 0, 0);
    host.xfer(CMD_UV_RESP, 8'hBF, 1, 0);
    host.xfer(CMD_RESTORE_ALL, 8'h00, 0, 0);
    rd(CMD_UV_RESP, 8'h00);
    cur = 8'h00;
    // Odd passes carry a mixed retry field, which must leave the register alone.
    for (int i = 0; i < 6; i++) begin
      d = 8'($random(seed));
      if (i % 2 == 1 && (d[5:3] == 3'h0 || d[5:3] == 3'h7)) d[5:3] = 3'h5;
      if (i % 2 == 0) d[5:3] = {3{d[5]}};
      if (i % 2 == 0) cur = {d[7], 1'b0, {6{d[5]}}};
      host.xfer(CMD_UV_RESP, d, 1, 0);
      rd(CMD_UV_RESP, cur);
    end
    rd(CMD_STATUS_CML, 8'h40);
    rd(CMD_STATUS_BYTE, 8'h02);
    see(16'(smbalert_oe), 16'h0001);
    do_reset(1'b1);
    host.xfer(CMD_UV_RESP, 8'h00, 0, 0);
    a = cmd_ack;
    host.xfer(8'h50, 8'h00, 0, 0);
    see(16'({a, cmd_ack}), 16'h0000);
    rd(CMD_STATUS_CML, 8'h80);
    see(16'(smbalert_oe), 16'h0001);
    see(16'({smbalert_out, sda_out}), 16'h0000);
    close_out();
  end
endmodule : vout_fault_response_ctrl_bench
